// File: jtb_tap.sv
// boundary-scan test access port: tap controller, instruction and data registers
//
// Overview of operation
// - sixteen-state controller stepped by tck, tms
// - power-on reset forces test-logic-reset
// - five-bit instruction selects the data register
// - undefined codes act as bypass
// - extest drives pins from chain, captures inputs
// - sample captures pins, preloads, pins normal
// - highz floats all pins, bypass shifts
// - clamp holds chain values, bypass shifts
// - idcode shifts out the identification word
// - one-bit bypass stage between tdi, tdo
// - chain covers every pin, not tap pins
// - five tap pins, tester drives four
// - identification word fields, bit zero one
// - parallel capture on rising tck
`timescale 1ns/1ps
`default_nettype none
module jtb_tap #(
    // identification fields, values arbitrary
    parameter logic [3:0] ID_VERSION = 4'h2,
    parameter logic [15:0] ID_PART = 16'h1234,
    parameter logic [10:0] ID_MFR = 11'h055
) (
    // clock and power-on reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // tap pins from the tester
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic trst_n_in,
    // serial test output, driven only while shifting
    output logic tdo_out,
    output logic tdo_oe_out,
    // core side of the covered pins
    input wire logic [jtb_pkg::NUM_PINS-1:0] core_out_in,
    input wire logic [jtb_pkg::NUM_PINS-1:0] core_oe_in,
    // pad side of the covered pins
    input wire logic [jtb_pkg::NUM_PINS-1:0] pin_in,
    output logic [jtb_pkg::NUM_PINS-1:0] pin_out,
    output logic [jtb_pkg::NUM_PINS-1:0] pin_oe_out
);
    localparam int NP = jtb_pkg::NUM_PINS;
    localparam int BL = jtb_pkg::BSR_LEN;
    localparam int CW = jtb_pkg::CTRL_W;

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers
    // map an instruction to the data register it selects
    function automatic jtb_pkg::jtb_sel_e sel_of(input logic [4:0] op);
        case (op)
            jtb_pkg::OP_EXTEST, jtb_pkg::OP_SAMPLE: sel_of = jtb_pkg::SEL_BSR;
            jtb_pkg::OP_IDCODE: sel_of = jtb_pkg::SEL_IDCODE;
            default: sel_of = jtb_pkg::SEL_BYPASS;
        endcase
    endfunction : sel_of
    // pins follow the update latches under extest and clamp
    function automatic logic chain_drives(input logic [4:0] op);
        chain_drives = (op == jtb_pkg::OP_EXTEST) || (op == jtb_pkg::OP_CLAMP);
    endfunction : chain_drives

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: every outside level passes two flops
    logic [CW-1:0] ctrl_s;
    logic [NP-1:0] pin_s;

    jtb_sync #(.W(CW + NP)) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in({pin_in, trst_n_in, tdi_in, tms_in, tck_in}),
        .q_out({pin_s, ctrl_s})
    );
    wire tck_s = ctrl_s[0];
    wire tms_s = ctrl_s[1];
    wire tdi_s = ctrl_s[2];
    wire trst_n_s = ctrl_s[3];
    // previous tck level, for edge finding
    logic tck_d_q;
    wire tck_rise = tck_s && !tck_d_q;
    wire tck_fall = !tck_s && tck_d_q;

    ////////////////////////////////////////////////////////////////////////////////
    // tap controller
    jtb_pkg::jtb_state_e st_q;
    jtb_pkg::jtb_state_e st_d;
    jtb_pkg::jtb_state_e st_nx;
    // standard transition table, chosen by tms
    always_comb
    begin
        case (st_q)
            jtb_pkg::TEST_LOGIC_RESET:
                st_nx = tms_s ? jtb_pkg::TEST_LOGIC_RESET : jtb_pkg::RUN_TEST_IDLE;
            jtb_pkg::RUN_TEST_IDLE: st_nx = tms_s ? jtb_pkg::SELECT_DR : jtb_pkg::RUN_TEST_IDLE;
            jtb_pkg::SELECT_DR: st_nx = tms_s ? jtb_pkg::SELECT_IR : jtb_pkg::CAPTURE_DR;
            jtb_pkg::CAPTURE_DR: st_nx = tms_s ? jtb_pkg::EXIT1_DR : jtb_pkg::SHIFT_DR;
            jtb_pkg::SHIFT_DR: st_nx = tms_s ? jtb_pkg::EXIT1_DR : jtb_pkg::SHIFT_DR;
            jtb_pkg::EXIT1_DR: st_nx = tms_s ? jtb_pkg::UPDATE_DR : jtb_pkg::PAUSE_DR;
            jtb_pkg::PAUSE_DR: st_nx = tms_s ? jtb_pkg::EXIT2_DR : jtb_pkg::PAUSE_DR;
            jtb_pkg::EXIT2_DR: st_nx = tms_s ? jtb_pkg::UPDATE_DR : jtb_pkg::SHIFT_DR;
            jtb_pkg::UPDATE_DR: st_nx = tms_s ? jtb_pkg::SELECT_DR : jtb_pkg::RUN_TEST_IDLE;
            jtb_pkg::SELECT_IR: st_nx = tms_s ? jtb_pkg::TEST_LOGIC_RESET : jtb_pkg::CAPTURE_IR;
            jtb_pkg::CAPTURE_IR: st_nx = tms_s ? jtb_pkg::EXIT1_IR : jtb_pkg::SHIFT_IR;
            jtb_pkg::SHIFT_IR: st_nx = tms_s ? jtb_pkg::EXIT1_IR : jtb_pkg::SHIFT_IR;
            jtb_pkg::EXIT1_IR: st_nx = tms_s ? jtb_pkg::UPDATE_IR : jtb_pkg::PAUSE_IR;
            jtb_pkg::PAUSE_IR: st_nx = tms_s ? jtb_pkg::EXIT2_IR : jtb_pkg::PAUSE_IR;
            jtb_pkg::EXIT2_IR: st_nx = tms_s ? jtb_pkg::UPDATE_IR : jtb_pkg::SHIFT_IR;
            jtb_pkg::UPDATE_IR: st_nx = tms_s ? jtb_pkg::SELECT_DR : jtb_pkg::RUN_TEST_IDLE;
            default: st_nx = jtb_pkg::TEST_LOGIC_RESET;
        endcase
    end
    // test reset pin wins over any tck edge; otherwise step on tck rise
    assign st_d = !trst_n_s ? jtb_pkg::TEST_LOGIC_RESET
                : (tck_rise ? st_nx : st_q);
    // power-on reset needs no tck activity
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q <= jtb_pkg::TEST_LOGIC_RESET;
            tck_d_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            tck_d_q <= tck_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // instruction register
    logic [jtb_pkg::IR_W-1:0] ir_q;
    logic [jtb_pkg::IR_W-1:0] ir_sh_q;
    wire at_tlr = (st_q == jtb_pkg::TEST_LOGIC_RESET);
    wire rise_in = tck_rise && trst_n_s;
    jtb_pkg::jtb_sel_e sel;
    assign sel = sel_of(ir_q);
    // shifter captures the fixed pattern; instruction loads on update
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ir_q <= jtb_pkg::OP_IDCODE;
            ir_sh_q <= '0;
        end
        else if (at_tlr)
            ir_q <= jtb_pkg::OP_IDCODE;
        else if (rise_in)
        begin
            if (st_q == jtb_pkg::CAPTURE_IR)
                ir_sh_q <= jtb_pkg::IR_CAPTURE;
            else if (st_q == jtb_pkg::SHIFT_IR)
                ir_sh_q <= {tdi_s, ir_sh_q[jtb_pkg::IR_W-1:1]};
            else if (st_q == jtb_pkg::UPDATE_IR)
                ir_q <= ir_sh_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data registers: bypass, identification, boundary chain
    logic byp_q;
    logic [jtb_pkg::ID_W-1:0] id_sh_q;
    logic [BL-1:0] bsr_q;
    logic [BL-1:0] bsr_upd_q;
    wire [jtb_pkg::ID_W-1:0] id_word = {ID_VERSION, ID_PART, ID_MFR, jtb_pkg::ID_FIXED_ONE};
    wire [BL-1:0] bsr_cap;
    // update latch images of the output value and enable cells
    logic [NP-1:0] pin_mux_o;
    logic [NP-1:0] pin_mux_e;
    // capture image: pad level, core output and core enable per pin
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_cell
            assign bsr_cap[gi*jtb_pkg::CELLS_PER_PIN + jtb_pkg::CELL_IN] = pin_s[gi];
            assign bsr_cap[gi*jtb_pkg::CELLS_PER_PIN + jtb_pkg::CELL_OUT] = core_out_in[gi];
            assign bsr_cap[gi*jtb_pkg::CELLS_PER_PIN + jtb_pkg::CELL_OE] = core_oe_in[gi];
            assign pin_mux_o[gi] = bsr_upd_q[gi*jtb_pkg::CELLS_PER_PIN + jtb_pkg::CELL_OUT];
            assign pin_mux_e[gi] = bsr_upd_q[gi*jtb_pkg::CELLS_PER_PIN + jtb_pkg::CELL_OE];
        end
    endgenerate

    // capture, shift and update of whichever register is selected
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            byp_q <= 1'b0;
            id_sh_q <= '0;
            bsr_q <= '0;
            bsr_upd_q <= '0;
        end
        else if (rise_in && st_q == jtb_pkg::CAPTURE_DR)
        begin
            byp_q <= 1'b0;
            if (sel == jtb_pkg::SEL_IDCODE)
                id_sh_q <= id_word;
            if (sel == jtb_pkg::SEL_BSR)
                bsr_q <= bsr_cap;
        end
        else if (rise_in && st_q == jtb_pkg::SHIFT_DR)
        begin
            byp_q <= tdi_s;
            id_sh_q <= {tdi_s, id_sh_q[jtb_pkg::ID_W-1:1]};
            if (sel == jtb_pkg::SEL_BSR)
                bsr_q <= {tdi_s, bsr_q[BL-1:1]};
        end
        else if (rise_in && st_q == jtb_pkg::UPDATE_DR && sel == jtb_pkg::SEL_BSR)
            bsr_upd_q <= bsr_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial output and pin drivers
    wire shift_ir = (st_q == jtb_pkg::SHIFT_IR);
    wire shift_dr = (st_q == jtb_pkg::SHIFT_DR);
    wire dr_lsb = (sel == jtb_pkg::SEL_BSR) ? bsr_q[0]
                : ((sel == jtb_pkg::SEL_IDCODE) ? id_sh_q[0] : byp_q);
    wire is_highz = (ir_q == jtb_pkg::OP_HIGHZ);
    wire use_chain = chain_drives(ir_q);
    wire [NP-1:0] pin_o_d = use_chain ? pin_mux_o : core_out_in;
    wire [NP-1:0] pin_e_d = is_highz ? '0 : (use_chain ? pin_mux_e : core_oe_in);
    // tdo moves on the falling tck edge so the tester samples it stable
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_out <= shift_ir ? ir_sh_q[0] : dr_lsb;
            tdo_oe_out <= shift_ir || shift_dr;
        end
    end
    // pin drivers are registered; one cycle of latency is the price
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_out <= '0;
            pin_oe_out <= '0;
        end
        else
        begin
            pin_out <= pin_o_d;
            pin_oe_out <= pin_e_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_cap_dr;
        rise_in && st_q == jtb_pkg::CAPTURE_DR;
    endsequence
    sequence s_upd_ir;
        rise_in && st_q == jtb_pkg::UPDATE_IR;
    endsequence
    a_por_tlr: assert property (@(posedge ref_clk_in)
        $fell(rst_in) |-> st_q == jtb_pkg::TEST_LOGIC_RESET)
        else $error("controller not in reset state after power-on");
    a_state_step: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (st_q != $past(st_q)) |-> ($past(tck_rise) || !$past(trst_n_s)))
        else $error("state moved without a tck rise");
    a_ir_load: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_upd_ir |=> ir_q == $past(ir_sh_q))
        else $error("instruction not loaded on update");
    a_undef_bypass: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (ir_q != jtb_pkg::OP_EXTEST && ir_q != jtb_pkg::OP_SAMPLE
         && ir_q != jtb_pkg::OP_IDCODE) |-> sel == jtb_pkg::SEL_BYPASS)
        else $error("unlisted code did not select bypass");
    a_extest_drive: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (ir_q == jtb_pkg::OP_EXTEST) ##1 (ir_q == jtb_pkg::OP_EXTEST)
        |-> pin_out == $past(pin_mux_o))
        else $error("extest pins not driven from chain");
    a_sample_normal: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (ir_q == jtb_pkg::OP_SAMPLE) |=> pin_out == $past(core_out_in))
        else $error("sample disturbed the pins");
    a_highz_float: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (ir_q == jtb_pkg::OP_HIGHZ) |=> pin_oe_out == '0)
        else $error("pin enabled under highz");
    a_clamp_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (ir_q == jtb_pkg::OP_CLAMP) |=> pin_out == $past(pin_mux_o))
        else $error("clamp pins not held from chain");
    a_id_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_cap_dr ##0 (sel == jtb_pkg::SEL_IDCODE) |=> id_sh_q == id_word && id_sh_q[0])
        else $error("identification word not captured");
    a_bypass_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_cap_dr |=> !byp_q)
        else $error("bypass stage not cleared on capture");
    a_tdo_fall: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $changed(tdo_oe_out) |-> $past(tck_fall))
        else $error("tdo enable moved off a falling tck");
endmodule : jtb_tap
`default_nettype wire

// File: jtb_pkg.sv
// shared constants for the boundary-scan test access port
package jtb_pkg;

    // instruction register width and codes
    localparam int IR_W = 5;
    localparam logic [4:0] OP_EXTEST = 5'h00;
    localparam logic [4:0] OP_SAMPLE = 5'h01;
    localparam logic [4:0] OP_CLAMP = 5'h04;
    localparam logic [4:0] OP_HIGHZ = 5'h05;
    localparam logic [4:0] OP_IDCODE = 5'h0C;
    localparam logic [4:0] OP_BYPASS = 5'h1F;
    // value loaded into the instruction shifter on capture
    localparam logic [4:0] IR_CAPTURE = 5'h01;

    // identification register layout
    localparam int ID_W = 32;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam logic [0:0] ID_FIXED_ONE = 1'h1;

    // boundary chain: three cells per pin (input, output, enable)
    localparam int NUM_PINS = 16;
    localparam int CELLS_PER_PIN = 3;
    localparam int BSR_LEN = NUM_PINS * CELLS_PER_PIN;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;

    // synchronised control pins: tck, tms, tdi, trst_n
    localparam int CTRL_W = 4;

    // tap controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } jtb_state_e;

    // data register selected by the current instruction
    typedef enum logic [1:0] {SEL_BYPASS, SEL_BSR, SEL_IDCODE} jtb_sel_e;

endpackage : jtb_pkg

// File: jtb_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module jtb_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // raw levels and their synchronised copies
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    // first stage is read by the second stage only
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // both stages clear to zero under reset
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;
endmodule : jtb_sync
`default_nettype wire

// File: jtb_tester.sv
// boundary-scan tester model that drives the tap pins of the device
`timescale 1ns/1ps
`default_nettype none
module jtb_tester (
    // reference clock that paces every pin change
    input wire logic ref_clk_in,
    // tap pins toward the device
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    output logic trst_n_out,
    // serial answer from the device
    input wire logic tdo_in
);
    // ref cycles: tms setup before the rise, tck high time, test reset pulse
    localparam int SETUP_CYC = 3;
    localparam int HIGH_CYC = 4;
    localparam int TRST_CYC = 8;
    // tck stands low between frames, test reset released
    initial
    begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
        trst_n_out = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // back to back steps give a 200 ns tck: 4 ref cycles low, 4 high
    // tms, tdi move one cycle after the fall, so they are stable at the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
    begin
        @(posedge ref_clk_in);
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (SETUP_CYC) @(posedge ref_clk_in);
        tck_out <= 1'b1;
        repeat (HIGH_CYC) @(posedge ref_clk_in);
        // tdo is taken just before the fall: the device only moves it after the fall
        tdo = tdo_in;
        tck_out <= 1'b0;
    end
    endtask : step
    // test reset pulse, long against the device's synchroniser
    task automatic pulse_reset();
    begin
        @(posedge ref_clk_in);
        trst_n_out <= 1'b0;
        repeat (TRST_CYC) @(posedge ref_clk_in);
        trst_n_out <= 1'b1;
        repeat (TRST_CYC) @(posedge ref_clk_in);
    end
    endtask : pulse_reset
endmodule : jtb_tester
`default_nettype wire

// File: tb.sv
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`default_nettype none
module tb;
    // identification fields, values arbitrary
    localparam logic [3:0] VER = 4'hA;
    localparam logic [15:0] PART = 16'h5A3C;
    localparam logic [10:0] MFR = 11'h2B5;
    localparam logic [63:0] ID_EXP = {32'h0, VER, PART, MFR, 1'b1};
    localparam int N = jtb_pkg::NUM_PINS;
    localparam logic [N-1:0] PRE_OUT = 16'hA5C3;
    localparam logic [N-1:0] PRE_OE = 16'h0FF0;
    // clock, reset and tap pins
    logic ref_clk_in, rst_in, tck, tms, tdi, trst_n, tdo_out, tdo_oe_out, b;
    // tdo floats when not driven, so a bit outside shifting never matches
    wire logic tdo_w = tdo_oe_out ? tdo_out : 1'bZ;
    // covered pins and scan vectors
    logic [N-1:0] core_out, core_oe, pin_in, pin_out, pin_oe;
    logic [63:0] pre, got, exp;
    int bad_count, n_tests, cycles;
    ////////////////////////////////////////////////////////////////////////////////
    jtb_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR)) i_jtb_tap (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
        .core_out_in(core_out), .core_oe_in(core_oe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_out(pin_oe));
    jtb_tester i_jtb_tester (.ref_clk_in(ref_clk_in), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .trst_n_out(trst_n), .tdo_in(tdo_w));
    // 40 MHz reference clock
    initial
    begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    // hang guard, well above the roughly 4500 cycles the run needs
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            $display("BAD t=%0t timeout", $time);
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
    begin
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask : wrap_up
    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string what);
    begin
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, g, e);
        end
    end
    endtask : chk
    // wait n edges, then step off the edge so outputs have settled
    task automatic wt(input int n);
    begin
        repeat (n) @(posedge ref_clk_in);
        #7;
    end
    endtask : wt
    task automatic set_pins(input logic [N-1:0] co, input logic [N-1:0] coe,
        input logic [N-1:0] pi);
    begin
        @(posedge ref_clk_in);
        core_out <= co;
        core_oe <= coe;
        pin_in <= pi;
        wt(4);
    end
    endtask : set_pins
    // one ir or dr scan of n bits, lsb first, from and back to run-test-idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
        output logic [63:0] dout);
    begin
        dout = '0;
        i_jtb_tester.step(1'b1, 1'b0, b);
        if (ir)
            i_jtb_tester.step(1'b1, 1'b0, b);
        i_jtb_tester.step(1'b0, 1'b0, b);
        i_jtb_tester.step(1'b0, 1'b0, b);
        for (int k = 0; k < n; k++)
        begin
            i_jtb_tester.step(k == n - 1, din[k], b);
            dout[k] = b;
        end
        i_jtb_tester.step(1'b1, 1'b0, b);
        i_jtb_tester.step(1'b0, 1'b0, b);
    end
    endtask : scan
    // every instruction load also checks the fixed capture pattern
    task automatic ld_ir(input logic [4:0] code);
    begin
        scan(1'b1, 5, {59'h0, code}, got);
        chk(got, 64'(jtb_pkg::IR_CAPTURE), "ir capture");
        wt(3);
    end
    endtask : ld_ir
    task automatic rd_id();
    begin
        scan(1'b0, 32, 64'h0, got);
        chk(got, ID_EXP, "idcode word");
    end
    endtask : rd_id
    ////////////////////////////////////////////////////////////////////////////////
    // power-on reset quiets outputs; afterwards idcode is selected, pins follow core
    task automatic t_reset();
    begin
        chk(64'({pin_out, pin_oe, tdo_oe_out}), 64'h0, "quiet in reset");
        @(posedge ref_clk_in);
        rst_in <= 1'b0;
        set_pins(16'h1234, 16'h00FF, 16'h0000);
        chk(64'({pin_out, pin_oe}), 64'h123400FF, "pins follow core");
        i_jtb_tester.step(1'b0, 1'b0, b);
        rd_id();
    end
    endtask : t_reset
    // bypass, highz, clamp and undefined codes all give a one-stage path
    task automatic t_bypass();
        logic [4:0] codes [8] = '{5'h1F, 5'h05, 5'h04, 5'h02, 5'h09, 5'h0A, 5'h03, 5'h1E};
    begin
        foreach (codes[i])
        begin
            ld_ir(codes[i]);
            scan(1'b0, 9, 64'h0AD, got);
            // bit 0 is the cleared capture of the single stage, then the data a bit late
            chk(64'(got[8:0]), 64'h15A, "one stage");
        end
    end
    endtask : t_bypass
    // sample captures pads and drivers, preloads, pins stay normal
    task automatic t_sample();
    begin
        set_pins(16'h1234, 16'h00FF, 16'hC3A5);
        ld_ir(jtb_pkg::OP_SAMPLE);
        chk(64'({pin_out, pin_oe}), 64'h123400FF, "sample pins");
        pre = '0;
        exp = '0;
        for (int i = 0; i < N; i++)
        begin
            pre[3*i+1] = PRE_OUT[i];
            pre[3*i+2] = PRE_OE[i];
            exp[3*i] = pin_in[i];
            exp[3*i+1] = core_out[i];
            exp[3*i+2] = core_oe[i];
        end
        scan(1'b0, jtb_pkg::BSR_LEN, pre, got);
        chk(got, exp, "sample capture");
    end
    endtask : t_sample
    // extest drives the preload and captures pads; clamp holds; highz floats
    task automatic t_extest();
    begin
        ld_ir(jtb_pkg::OP_EXTEST);
        chk(64'({pin_out, pin_oe}), 64'({PRE_OUT, PRE_OE}), "extest drive");
        set_pins(16'h1234, 16'h00FF, 16'h3C96);
        scan(1'b0, jtb_pkg::BSR_LEN, pre, got);
        for (int i = 0; i < N; i++)
            exp[i] = got[3*i];
        chk(64'(exp[N-1:0]), 64'h3C96, "extest capture");
        ld_ir(jtb_pkg::OP_CLAMP);
        chk(64'({pin_out, pin_oe}), 64'({PRE_OUT, PRE_OE}), "clamp hold");
        ld_ir(jtb_pkg::OP_HIGHZ);
        chk(64'(pin_oe), 64'h0, "highz float");
        ld_ir(jtb_pkg::OP_BYPASS);
        chk(64'({pin_out, pin_oe}), 64'h123400FF, "bypass pins");
    end
    endtask : t_extest
    // five tms highs, test reset pin and a mid-run reset all bring back idcode
    task automatic t_resets();
    begin
        ld_ir(jtb_pkg::OP_BYPASS);
        chk(64'(tdo_oe_out), 64'h0, "tdo idle");
        repeat (5) i_jtb_tester.step(1'b1, 1'b0, b);
        i_jtb_tester.step(1'b0, 1'b0, b);
        rd_id();
        ld_ir(jtb_pkg::OP_BYPASS);
        i_jtb_tester.pulse_reset();
        i_jtb_tester.step(1'b0, 1'b0, b);
        rd_id();
        ld_ir(jtb_pkg::OP_BYPASS);
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        wt(3);
        chk(64'({pin_out, pin_oe}), 64'h0, "quiet in reset");
        @(posedge ref_clk_in);
        rst_in <= 1'b0;
        wt(3);
        i_jtb_tester.step(1'b0, 1'b0, b);
        rd_id();
    end
    endtask : t_resets
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        bad_count = 0;
        n_tests = 0;
        cycles = 0;
        rst_in = 1'b1;
        core_out = '0;
        core_oe = '0;
        pin_in = '0;
        wt(2);
        t_reset();
        t_bypass();
        t_sample();
        t_extest();
        t_resets();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
